/* File: rtl/mrp_pkg.sv */
/*
 * constants, mode type and address decode for the 16x16 multiply result path.
 * assumes word-aligned 16-bit addresses from the peripheral register bus.
 */
package mrp_pkg;

    // register word addresses
    localparam logic [15:0] ADDR_OPA_UNS = 16'h0130;
    localparam logic [15:0] ADDR_OPA_SGN = 16'h0132;
    localparam logic [15:0] ADDR_OPA_MACU = 16'h0134;
    localparam logic [15:0] ADDR_OPA_OPERAND_A_ACCUM_SIGNED = 16'h0136;
    localparam logic [15:0] ADDR_OPB = 16'h0138;
    localparam logic [15:0] ADDR_RES_LO = 16'h013A;
    localparam logic [15:0] ADDR_RES_HI = 16'h013C;
    localparam logic [15:0] ADDR_RES_EXT = 16'h013E;

    // field layout and fixed values
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam logic [15:0] EXT_ZERO = 16'h0000;
    localparam logic [15:0] EXT_ONES = 16'hFFFF;
    localparam logic [15:0] EXT_CARRY = 16'h0001;
    localparam logic [15:0] RDATA_RST = 16'h0000;

    // cycles from second-operand write edge to finished result
    localparam int unsigned RESULT_CYCLES = 3;

    typedef enum logic [1:0] {
        MRP_UNSIGNED_PRODUCT_MODE,
        MRP_SIGNED_PRODUCT_MODE,
        MRP_UNSIGNED_ACCUMULATE_MODE,
        MRP_SIGNED_ACCUMULATE_MODE
    } mrp_mode_t;

    // first-operand alias address to operation mode
    function automatic mrp_mode_t mrp_addr_mode(input logic [15:0] addr);
        case (addr)
            ADDR_OPA_SGN: mrp_addr_mode = MRP_SIGNED_PRODUCT_MODE;
            ADDR_OPA_MACU: mrp_addr_mode = MRP_UNSIGNED_ACCUMULATE_MODE;
            ADDR_OPA_OPERAND_A_ACCUM_SIGNED: mrp_addr_mode = MRP_SIGNED_ACCUMULATE_MODE;
            default: mrp_addr_mode = MRP_UNSIGNED_PRODUCT_MODE;
        endcase
    endfunction

    // true for any of the four first-operand aliases
    function automatic logic mrp_is_opa(input logic [15:0] addr);
        mrp_is_opa = (addr == ADDR_OPA_UNS) || (addr == ADDR_OPA_SGN) ||
                     (addr == ADDR_OPA_MACU) || (addr == ADDR_OPA_OPERAND_A_ACCUM_SIGNED);
    endfunction

    function automatic logic mrp_is_signed(input mrp_mode_t m);
        mrp_is_signed = (m == MRP_SIGNED_PRODUCT_MODE) || (m == MRP_SIGNED_ACCUMULATE_MODE);
    endfunction

endpackage

/* File: rtl/mrp_mult_core.sv */
/*
 * two-stage 16x16 multiplier: operands and mode captured on start,
 * product registered one edge later together with a done pulse.
 * assumes start is a one-cycle strobe from the register decode.
 */
`timescale 1ns/10ps
module mrp_mult_core
    import mrp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [15:0] opa,
    input wire logic [15:0] opb,
    input wire mrp_mode_t mode,
    output logic [31:0] product_q,
    output mrp_mode_t mode_out_q,
    output logic done_q
);

    logic [15:0] a_q;
    logic [15:0] b_q;
    logic go_q;
    logic sgn;
    logic [16:0] a_ext;
    logic [16:0] b_ext;
    logic [33:0] prod_full;
    logic [31:0] product_d;

    // sign or zero extend to 17 bits so one signed multiplier covers both modes
    assign sgn = mrp_is_signed(mode_out_q);
    assign a_ext = {sgn & a_q[15], a_q};
    assign b_ext = {sgn & b_q[15], b_q};
    // operands widened to the full product width so no operand size rule can truncate it
    assign prod_full = {{17{a_ext[16]}}, a_ext} * {{17{b_ext[16]}}, b_ext};
    assign product_d = prod_full[31:0];

    // stage one: operand capture, so later operand writes cannot disturb a run
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            go_q <= 1'b0;
            mode_out_q <= MRP_UNSIGNED_PRODUCT_MODE;
        end else begin
            go_q <= start;
            if (start) begin
                mode_out_q <= mode;
            end
        end
    end

    // operand copies carry no reset, they are pure datapath
    always_ff @(posedge clk) begin
        if (start) begin
            a_q <= opa;
            b_q <= opb;
        end
    end

    // stage two: product and done
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            product_q <= 32'h0000_0000;
        end else begin
            done_q <= go_q;
            if (go_q) begin
                product_q <= product_d;
            end
        end
    end

    // signed product is a true two's complement 32-bit value
    a_signed_product: assert property (@(posedge clk) disable iff (!rst_n)
        (start && mrp_is_signed(mode)) |-> ##2
        ($signed(product_q) == ($signed($past(opa, 2)) * $signed($past(opb, 2)))))
        else $error("signed product wrong");

endmodule

/* File: rtl/mrp_result_path.sv */
/*
 * 16x16 multiply / multiply-accumulate peripheral register block.
 * assumes a simple word bus synchronous to CLK: one-cycle BUS_WR / BUS_RD
 * strobes, BUS_BYTE marks a byte write, read data registered one edge later.
 */
// Summary of operation
// - last written first-operand alias selects mode; that write starts nothing.
// - each second-operand write starts an operation with the stored first operand.
// - all result words are finished three cycles after the second-operand write.
// - low result word always takes result bits 15 to 0.
// - unsigned and accumulate modes put upper sixteen result bits in the high word.
// - signed product high word carries the sign and the upper result bits.
// - signed modes give two's complement results across high and low words.
// - unsigned product mode loads the extension word with zero.
// - signed modes load extension with all ones if negative, else zero.
// - unsigned accumulate loads extension with one on carry out, else zero.
// - signed accumulate treats bit 31 set as negative, clear as positive.
// - no overflow flag; in signed modes extension just mirrors the wrapped result's sign.
// - word decode: four aliases, second operand, low, high, read-only extension.
// - reset keeps operands; result and extension words have no reset value.
`timescale 1ns/10ps
module mrp_result_path
    import mrp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [15:0] BUS_ADDR,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    input wire logic BUS_BYTE,
    input wire logic [15:0] BUS_WDATA,
    output logic [15:0] BUS_RDATA
);

    logic [15:0] opa_q;
    logic [15:0] opb_q;
    logic [15:0] res_lo_q;
    logic [15:0] res_hi_q;
    logic [15:0] res_ext_q;
    mrp_mode_t mode_q;
    logic [31:0] product;
    mrp_mode_t run_mode;
    logic done;

    // write data, byte writes zero the upper half
    logic [15:0] wdata;
    assign wdata = BUS_BYTE ? {8'h00, BUS_WDATA[7:0]} : BUS_WDATA;

    // address decode
    logic wr_opa;
    logic wr_opb;
    logic wr_lo;
    logic wr_hi;
    assign wr_opa = BUS_WR && mrp_is_opa(BUS_ADDR);
    assign wr_opb = BUS_WR && (BUS_ADDR == ADDR_OPB);
    assign wr_lo = BUS_WR && (BUS_ADDR == ADDR_RES_LO);
    assign wr_hi = BUS_WR && (BUS_ADDR == ADDR_RES_HI);

    // read mux; unmapped addresses and the write-ignoring extension word decoded here
    logic [15:0] rdata_d;
    assign rdata_d = mrp_is_opa(BUS_ADDR) ? opa_q :
                     (BUS_ADDR == ADDR_OPB) ? opb_q :
                     (BUS_ADDR == ADDR_RES_LO) ? res_lo_q :
                     (BUS_ADDR == ADDR_RES_HI) ? res_hi_q :
                     (BUS_ADDR == ADDR_RES_EXT) ? res_ext_q : RDATA_RST;

    // the multiplier reads the operand straight off the bus so it sees this write
    mrp_mult_core u_core (
        .clk(CLK),
        .rst_n(RST_N),
        .start(wr_opb),
        .opa(opa_q),
        .opb(wdata),
        .mode(mode_q),
        .product_q(product),
        .mode_out_q(run_mode),
        .done_q(done)
    );

    // accumulate arithmetic; 33 bits keep the unsigned carry
    logic is_acc;
    logic [31:0] acc_base;
    logic [32:0] sum33;
    logic [31:0] res_d;
    logic [15:0] ext_d;
    assign is_acc = (run_mode == MRP_UNSIGNED_ACCUMULATE_MODE) || (run_mode == MRP_SIGNED_ACCUMULATE_MODE);
    assign acc_base = is_acc ? {res_hi_q, res_lo_q} : 32'h0000_0000;
    assign sum33 = {1'b0, acc_base} + {1'b0, product};
    assign res_d = sum33[31:0];

    // extension word: overflow is not flagged; signed modes show only the wrapped sign, unsigned accumulate the carry
    always_comb begin
        case (run_mode)
            MRP_UNSIGNED_PRODUCT_MODE: ext_d = EXT_ZERO;
            MRP_UNSIGNED_ACCUMULATE_MODE: ext_d = sum33[32] ? EXT_CARRY : EXT_ZERO;
            MRP_SIGNED_PRODUCT_MODE: ext_d = res_d[31] ? EXT_ONES : EXT_ZERO;
            MRP_SIGNED_ACCUMULATE_MODE: ext_d = res_d[31] ? EXT_ONES : EXT_ZERO;
            default: ext_d = EXT_ZERO;
        endcase
    end

    // mode selection is control state, so it has a reset value, as does the read data register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            mode_q <= MRP_UNSIGNED_PRODUCT_MODE;
        end else if (wr_opa) begin
            mode_q <= mrp_addr_mode(BUS_ADDR);
        end
    end

    // operands survive reset, they have no reset branch at all
    always_ff @(posedge CLK) begin
        if (wr_opa) begin
            opa_q <= wdata;
        end
        if (wr_opb) begin
            opb_q <= wdata;
        end
    end

    // results: a finishing operation beats a host write in the same cycle
    always_ff @(posedge CLK) begin
        if (done) begin
            res_lo_q <= res_d[15:0];
            res_hi_q <= res_d[31:16];
            res_ext_q <= ext_d;
        end else begin
            if (wr_lo) begin
                res_lo_q <= wdata;
            end
            if (wr_hi) begin
                res_hi_q <= wdata;
            end
        end
    end

    // registered read port
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            BUS_RDATA <= RDATA_RST;
        end else if (BUS_RD) begin
            BUS_RDATA <= rdata_d;
        end
    end

    sequence s_opb_write;
        wr_opb && !done;
    endsequence

    sequence s_result_land;
        ##2 done ##1 1'b1;
    endsequence

    a_mode_select: assert property (@(posedge CLK) disable iff (!RST_N)
        (BUS_WR && (BUS_ADDR == ADDR_OPA_OPERAND_A_ACCUM_SIGNED)) |=> (mode_q == MRP_SIGNED_ACCUMULATE_MODE))
        else $error("mode not taken from alias address");

    a_opa_no_start: assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_opa && !wr_opb && !$past(wr_opb)) |=> ##1 !done)
        else $error("first operand write started a run");

    a_opb_latency: assert property (@(posedge CLK) disable iff (!RST_N)
        s_opb_write |-> s_result_land)
        else $error("result not finished in time");

    a_plain_product: assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_opb && (mode_q == MRP_UNSIGNED_PRODUCT_MODE)) |-> ##3
        ({res_hi_q, res_lo_q} == ({16'h0000, $past(opa_q, 3)} * {16'h0000, $past(wdata, 3)})))
        else $error("unsigned product words wrong");

    a_ext_zero: assert property (@(posedge CLK) disable iff (!RST_N)
        (done && (run_mode == MRP_UNSIGNED_PRODUCT_MODE)) |=> (res_ext_q == EXT_ZERO))
        else $error("extension not zero in unsigned product");

    a_ext_sign: assert property (@(posedge CLK) disable iff (!RST_N)
        (done && mrp_is_signed(run_mode)) |=> (res_ext_q == {16{res_hi_q[15]}}))
        else $error("extension does not mirror sign");

    a_acc_carry: assert property (@(posedge CLK) disable iff (!RST_N)
        (done && (run_mode == MRP_UNSIGNED_ACCUMULATE_MODE)) |=>
        ({res_ext_q[0], res_hi_q, res_lo_q} ==
         ({1'b0, $past(res_hi_q), $past(res_lo_q)} + {1'b0, $past(product)})))
        else $error("unsigned accumulate sum or carry wrong");

    a_byte_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        (wr_opb && BUS_BYTE) |=> (opb_q[15:8] == 8'h00))
        else $error("byte write left upper bits");

    a_ext_read_only: assert property (@(posedge CLK) disable iff (!RST_N)
        (BUS_WR && (BUS_ADDR == ADDR_RES_EXT) && !done) |=> $stable(res_ext_q))
        else $error("extension word took a write");

endmodule

/* File: verification/mrp_host_model.sv */
/*
 * host bus master model for the multiply result path.
 * assumes the peripheral samples its strobes on the rising CLK edge.
 */
`timescale 1ns/10ps
module mrp_host_model (
    input wire logic CLK,
    output logic [15:0] BUS_ADDR,
    output logic BUS_WR,
    output logic BUS_RD,
    output logic BUS_BYTE,
    output logic [15:0] BUS_WDATA,
    input wire logic [15:0] BUS_RDATA
);
    // idle bus at time zero
    initial begin
        BUS_ADDR = 16'h0000;
        BUS_WR = 1'b0;
        BUS_RD = 1'b0;
        BUS_BYTE = 1'b0;
        BUS_WDATA = 16'h5A5A;
    end
    // one transfer, held over the sampling edge
    // byte data goes out raw, the device zeroes the upper byte
    task automatic op(input logic [15:0] a, input logic w, input logic b, input logic [15:0] d,
                      output logic [15:0] q);
        @(negedge CLK);
        BUS_ADDR = a;
        BUS_WR = w;
        BUS_RD = ~w;
        BUS_BYTE = b;
        BUS_WDATA = d;
        @(posedge CLK);
        #1 q = BUS_RDATA;
    endtask
    // release; data flips so a stale word never passes for a fresh one
    task automatic idle();
        @(negedge CLK);
        BUS_WR = 1'b0;
        BUS_RD = 1'b0;
        BUS_WDATA = ~BUS_WDATA;
    endtask
endmodule

/* File: verification/testbench.sv */
/*
 * self-checking bench for the multiply result path.
 * assumes the host model drives the bus and results land three edges on.
 */
`timescale 1ns/10ps
module testbench;
    import mrp_pkg::*;
    logic CLK;
    logic RST_N;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic wr;
    logic rd;
    logic byt;
    int seed = 54252;
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    logic [15:0] m_opa;
    logic [15:0] q;
    logic [31:0] m_res;
    logic [15:0] m_ext;
    logic [31:0] r;
    mrp_mode_t m_mode;

    mrp_result_path mrp_result_path_i (.CLK(CLK), .RST_N(RST_N), .BUS_ADDR(addr), .BUS_WR(wr),
        .BUS_RD(rd), .BUS_BYTE(byt), .BUS_WDATA(wdata), .BUS_RDATA(rdata));
    mrp_host_model mrp_host_model_i (.CLK(CLK), .BUS_ADDR(addr), .BUS_WR(wr), .BUS_RD(rd),
        .BUS_BYTE(byt), .BUS_WDATA(wdata), .BUS_RDATA(rdata));

    // expected {extension, result}; signed extension mirrors the wrapped result's sign
    function automatic logic [47:0] exp_op(input mrp_mode_t m, input logic [15:0] a,
                                           input logic [15:0] b, input logic [31:0] acc);
        logic [31:0] p;
        logic [32:0] s;
        logic sg;
        sg = (m == MRP_SIGNED_PRODUCT_MODE) || (m == MRP_SIGNED_ACCUMULATE_MODE);
        p = sg ? {{16{a[15]}}, a} * {{16{b[15]}}, b} : {16'h0000, a} * {16'h0000, b};
        s = {1'b0, p};
        if (m == MRP_UNSIGNED_ACCUMULATE_MODE || m == MRP_SIGNED_ACCUMULATE_MODE) begin
            s = {1'b0, acc} + {1'b0, p};
        end
        exp_op = {sg ? {16{s[31]}} : (m == MRP_UNSIGNED_ACCUMULATE_MODE ? {15'h0000, s[32]} : EXT_ZERO), s[31:0]};
    endfunction

    task automatic wr_w(input logic [15:0] a, input logic [15:0] d, input logic b);
        logic [15:0] x;
        mrp_host_model_i.op(a, 1'b1, b, d, x);
    endtask
    task automatic chk_rd(input logic [15:0] a, input logic [15:0] e);
        mrp_host_model_i.op(a, 1'b0, 1'b0, 16'h0000, q);
        checked++;
        if (q !== e) begin
            failures++;
            $display("ERROR %0t read %h got %h expected %h", $time, a, q, e);
        end
    endtask
    // aliases sit two bytes apart in mode order
    task automatic load_a(input logic [1:0] m, input logic [15:0] a, input logic b);
        wr_w(ADDR_OPA_UNS + {13'h0000, m, 1'b0}, a, b);
        m_mode = mrp_mode_t'(m);
        m_opa = b ? {8'h00, a[7:0]} : a;
    endtask
    // start, wait the fixed latency, then read all three words
    task automatic start_b(input logic [15:0] bv, input logic b);
        logic [47:0] e;
        e = exp_op(m_mode, m_opa, b ? {8'h00, bv[7:0]} : bv, m_res);
        wr_w(ADDR_OPB, bv, b);
        mrp_host_model_i.idle();
        mrp_host_model_i.idle();
        m_res = e[31:0];
        m_ext = e[47:32];
        chk_rd(ADDR_RES_LO, m_res[15:0]);
        chk_rd(ADDR_RES_HI, m_res[31:16]);
        chk_rd(ADDR_RES_EXT, e[47:32]);
    endtask
    // two starts on consecutive cycles; the second result builds on the first
    task automatic twice_b(input logic [15:0] b1, input logic [15:0] b2);
        logic [47:0] e;
        e = exp_op(m_mode, m_opa, b1, m_res);
        e = exp_op(m_mode, m_opa, b2, e[31:0]);
        wr_w(ADDR_OPB, b1, 1'b0);
        wr_w(ADDR_OPB, b2, 1'b0);
        mrp_host_model_i.idle();
        mrp_host_model_i.idle();
        m_res = e[31:0];
        m_ext = e[47:32];
        chk_rd(ADDR_RES_LO, m_res[15:0]);
        chk_rd(ADDR_RES_HI, m_res[31:16]);
        chk_rd(ADDR_RES_EXT, m_ext);
    endtask
    task automatic corner(input logic [31:0] pre, input logic [1:0] m, input logic [15:0] a,
                          input logic [15:0] b);
        wr_w(ADDR_RES_LO, pre[15:0], 1'b0);
        wr_w(ADDR_RES_HI, pre[31:16], 1'b0);
        m_res = pre;
        load_a(m, a, 1'b0);
        start_b(b, 1'b0);
    endtask

    task automatic results();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // hang guard well above the few hundred cycles the run needs
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            $display("ERROR %0t timeout", $time);
            results();
        end
    end

    initial begin
        RST_N = 1'b0;
        repeat (12) @(negedge CLK);
        RST_N = 1'b1;
        // wrap-around and carry corners for every mode, two in signed accumulate
        corner(32'h7FFFFFFF, 2'd3, 16'h0001, 16'h0001);
        corner(32'h80000000, 2'd3, 16'hFFFF, 16'h0001);
        corner(32'hFFFFFFFF, 2'd2, 16'h0001, 16'h0001);
        corner(32'h00000000, 2'd1, 16'h8000, 16'h7FFF);
        corner(32'h00000000, 2'd0, 16'hFFFF, 16'hFFFF);
        // random mix, sometimes reusing the stored first operand
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            if (r[1:0] != 2'b00) begin
                load_a(r[3:2], r[19:4], r[20]);
            end
            start_b(r[31:16], r[21]);
        end
        // back-to-back starts must land in order so accumulates chain
        load_a(2'd2, 16'hFFFF, 1'b0);
        twice_b(16'hFFFF, 16'hFFFF);
        load_a(2'd3, 16'h8000, 1'b0);
        twice_b(16'h8000, 16'h7FFF);
        // alias write alone leaves results untouched
        load_a(2'd2, 16'h1234, 1'b0);
        mrp_host_model_i.idle();
        mrp_host_model_i.idle();
        chk_rd(ADDR_RES_LO, m_res[15:0]);
        chk_rd(16'h0140, 16'h0000);
        wr_w(ADDR_RES_EXT, 16'h5555, 1'b0);
        chk_rd(ADDR_RES_EXT, m_ext);
        // reset between operations keeps operand, mode back to unsigned product
        @(negedge CLK);
        RST_N = 1'b0;
        repeat (2) @(negedge CLK);
        RST_N = 1'b1;
        m_mode = MRP_UNSIGNED_PRODUCT_MODE;
        chk_rd(ADDR_OPA_UNS, m_opa);
        start_b(16'hBEEF, 1'b0);
        results();
    end
endmodule
